// ==== logic/tap_pkg.sv ====
package tap_pkg;
  // register byte offsets on the lite bus
  localparam logic [7:0] CTRL_OFS   = 8'h00; // options and axis enables
  localparam logic [7:0] THRESH_OFS = 8'h04; // per-axis tap thresholds
  localparam logic [7:0] LAT_OFS    = 8'h08; // latency interval, cycles
  localparam logic [7:0] WIN_OFS    = 8'h0c; // second-pulse window, cycles
  localparam logic [7:0] STAT_OFS   = 8'h10; // event status, read clears when events are latched
  localparam logic [7:0] MASK_OFS   = 8'h14; // interrupt mask, status layout

  // control register fields
  localparam int LATCH_BIT = 0; // keep events until status is read
  localparam int IGN_BIT   = 1; // ignore latency interval
  localparam int SP_LSB    = 2; // single-pulse enables x,y,z
  localparam int DP_LSB    = 5; // double_pulse_axis_enable x,y,z
  localparam int CTRL_W    = 8;

  // threshold register fields, one byte per axis
  localparam int THR_W   = 8;
  localparam int THR_LSB = 0;

  // status and mask fields
  localparam int EVT_BIT = 0; // combined event detected
  localparam int DBL_BIT = 1; // double tap recognised
  localparam int AXF_LSB = 2; // per-axis detected x,y,z
  localparam int DIR_LSB = 5; // per-axis direction x,y,z (1 = negative)
  localparam int STAT_W  = 8;

  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_00fd;
  localparam logic [31:0] THRESH_RST = 32'h0010_1010;
  localparam logic [31:0] LAT_RST    = 32'h0000_0010;
  localparam logic [31:0] WIN_RST    = 32'h0000_0040;
  localparam logic [31:0] MASK_RST   = 32'h0000_0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // double tap recogniser states
  typedef enum logic [0:0] {DT_IDLE, DT_ARMED} dt_state_t;
endpackage

// ==== logic/tap_if.sv ====
`timescale 1ns/1ps
// per-axis qualified tap pulses between qualifier and recogniser
interface tap_if;
  logic [2:0] pulse; // one-cycle tap per axis
  logic [2:0] dir;   // sign of the tap, 1 = negative
  modport src (output pulse, output dir);
  modport snk (input pulse, input dir);
endinterface

// ==== logic/tap_qualifier.sv ====
`timescale 1ns/1ps
module tap_qualifier (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  // sample stream, same clock domain
  input  wire logic                       sample_valid,
  input  wire logic [3*tap_pkg::THR_W-1:0] sample_mag,
  input  wire logic [2:0]                 sample_neg,
  input  wire logic [3*tap_pkg::THR_W-1:0] thresh,
  // qualified taps
  tap_if.src                              tap
);
  logic [2:0] above_q; // axis currently above its threshold
  logic [2:0] above_d;
  logic [2:0] ge_vec;  // sample reaches threshold this cycle
  logic [2:0] pulse_q;
  logic [2:0] pulse_d;
  logic [2:0] dir_q;
  logic [2:0] dir_d;

  // compare and edge detect; one tap per crossing so a long shock
  // does not count as a burst of taps
  always_comb begin
    above_d = above_q;
    pulse_d = 3'h0;
    dir_d   = dir_q;
    for (int i = 0; i < 3; i++) begin
      ge_vec[i] = sample_mag[i*tap_pkg::THR_W +: tap_pkg::THR_W]
                  >= thresh[i*tap_pkg::THR_W +: tap_pkg::THR_W];
      if (sample_valid) begin
        // below threshold: disregarded, only re-arms the edge
        above_d[i] = ge_vec[i];
        if (ge_vec[i] && !above_q[i]) begin
          pulse_d[i] = 1'b1;
          dir_d[i]   = sample_neg[i];
        end
      end
    end
  end

  // register state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      above_q <= 3'h0;
      pulse_q <= 3'h0;
      dir_q   <= 3'h0;
    end else begin
      above_q <= above_d;
      pulse_q <= pulse_d;
      dir_q   <= dir_d;
    end
  end

  assign tap.pulse = pulse_q;
  assign tap.dir   = dir_q;

  // a tap never comes from a sample under threshold
  a_thresh_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    (pulse_q != 3'h0) |-> ((pulse_q & ~$past(ge_vec)) == 3'h0))
    else $error("tap raised for sample below threshold");
endmodule

// ==== logic/double_tap_detector.sv ====
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module double_tap_detector #(
  parameter int CNT_W = 16 // width of latency and window counts
) (
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           nrst,
  // acceleration samples, same clock domain
  input  wire logic           sample_valid,
  input  wire logic [23:0]    sample_mag,
  input  wire logic [2:0]     sample_neg,
  // lite bus write address
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [7:0]     s_axi_awaddr,
  // lite bus write data
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  // lite bus write response
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  output logic [1:0]          s_axi_bresp,
  // lite bus read address
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  input  wire logic [7:0]     s_axi_araddr,
  // lite bus read data
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  // interrupt
  output logic                irq
);
  // refuse counter widths the registers cannot hold
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
    $error("CNT_W must lie between 2 and 32");
  end

  tap_if tap ();

  // configuration registers
  logic [31:0]              ctrl_q, ctrl_d;
  logic [31:0]              thr_q, thr_d;
  logic [31:0]              lat_q, lat_d;
  logic [31:0]              win_q, win_d;
  logic [31:0]              mask_q, mask_d;
  logic [tap_pkg::STAT_W-1:0] stat_q, stat_d; // event status
  logic                     irq_d;

  // decoded options
  logic                     latch_en;   // events sticky until read
  logic                     ign_lat;    // latency bypass
  logic [2:0]               sp_en;      // single-pulse enables
  logic [2:0]               dp_en;      // double_pulse_axis_enable
  logic [CNT_W-1:0]         lat_cfg;
  logic [CNT_W-1:0]         win_cfg;

  // bus slave state
  logic                     aw_hold_q, aw_hold_d; // address taken
  logic [7:0]               aw_addr_q, aw_addr_d;
  logic                     w_hold_q, w_hold_d;   // data taken
  logic [31:0]              w_data_q, w_data_d;
  logic [3:0]               w_strb_q, w_strb_d;
  logic                     bvalid_q, bvalid_d;
  logic [1:0]               bresp_q, bresp_d;
  logic                     rvalid_q, rvalid_d;
  logic [31:0]              rdata_q, rdata_d;
  logic [1:0]               rresp_q, rresp_d;
  logic                     wr_go;      // both halves present
  logic                     rd_go;      // read address handshake
  logic                     rd_stat;    // read of status this cycle

  // recogniser state
  tap_pkg::dt_state_t       st_q, st_d;
  logic [CNT_W-1:0]         el_q, el_d;  // cycles since first pulse
  logic [2:0]               dp_pulse;    // taps on double-enabled axes
  logic [2:0]               sp_pulse;    // taps on single-enabled axes
  logic                     expire;      // window ran out
  logic                     first_tap;   // tap that opens a window
  logic                     dbl_hit;     // double tap recognised
  logic [2:0]               axis_hit;    // axes reporting this event
  logic                     evt_any;     // any single or double event
  logic [tap_pkg::STAT_W-1:0] ev_vec;   // event in status layout

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // address hits a mapped register
  function automatic logic mapped(input logic [7:0] a);
    return a == tap_pkg::CTRL_OFS || a == tap_pkg::THRESH_OFS ||
           a == tap_pkg::LAT_OFS  || a == tap_pkg::WIN_OFS    ||
           a == tap_pkg::STAT_OFS || a == tap_pkg::MASK_OFS;
  endfunction

  // per-axis threshold compare and edge detection
  tap_qualifier u_qual (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .sample_valid (sample_valid),
    .sample_mag   (sample_mag),
    .sample_neg   (sample_neg),
    .thresh       (thr_q[23:0]),
    .tap          (tap.src)
  );

  // option decode
  assign latch_en = ctrl_q[tap_pkg::LATCH_BIT];
  assign ign_lat  = ctrl_q[tap_pkg::IGN_BIT];
  assign sp_en    = ctrl_q[tap_pkg::SP_LSB +: 3];
  assign dp_en    = ctrl_q[tap_pkg::DP_LSB +: 3];
  assign lat_cfg  = lat_q[CNT_W-1:0];
  assign win_cfg  = win_q[CNT_W-1:0];

  // bus handshakes; a write completes once both halves are held
  assign wr_go   = aw_hold_q && w_hold_q && !bvalid_q;
  assign rd_go   = s_axi_arvalid && !rvalid_q;
  assign rd_stat = rd_go && s_axi_araddr == tap_pkg::STAT_OFS;

  // tap routing per axis enable
  assign dp_pulse = tap.pulse & dp_en;
  assign sp_pulse = tap.pulse & sp_en;

  // window expiry and double recognition
  always_comb begin
    expire    = st_q == tap_pkg::DT_ARMED && el_q >= win_cfg;
    // latency bypass or elapsed latency, still inside the window
    dbl_hit   = st_q == tap_pkg::DT_ARMED && !expire && (|dp_pulse) &&
                (ign_lat || el_q >= lat_cfg);
    // a tap after expiry is a fresh first pulse
    first_tap = (|dp_pulse) && (st_q == tap_pkg::DT_IDLE || expire);
    axis_hit  = sp_pulse | (dbl_hit ? dp_pulse : 3'h0);
    evt_any   = (|sp_pulse) || dbl_hit;
    ev_vec    = '0;
    ev_vec[tap_pkg::EVT_BIT]         = evt_any;
    ev_vec[tap_pkg::DBL_BIT]         = dbl_hit;
    ev_vec[tap_pkg::AXF_LSB +: 3]    = axis_hit;
    ev_vec[tap_pkg::DIR_LSB +: 3]    = axis_hit & tap.dir;
  end

  // recogniser next state
  always_comb begin
    st_d = st_q;
    el_d = el_q;
    unique case (st_q)
      tap_pkg::DT_IDLE: begin
        if (first_tap) begin
          st_d = tap_pkg::DT_ARMED;
          el_d = '0;
        end
      end
      tap_pkg::DT_ARMED: begin
        if (first_tap) begin
          el_d = '0; // restart window on the new first pulse
        end else if (dbl_hit || expire) begin
          st_d = tap_pkg::DT_IDLE;
        end else if (el_q != {CNT_W{1'b1}}) begin
          el_d = el_q + 1'b1; // taps here are dropped
        end
      end
    endcase
  end

  // recogniser registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= tap_pkg::DT_IDLE;
      el_q <= '0;
    end else begin
      st_q <= st_d;
      el_q <= el_d;
    end
  end

  // status and interrupt next state
  always_comb begin
    if (latch_en) begin
      // sticky; a new event in the clearing read's cycle survives
      stat_d = (rd_stat ? '0 : stat_q) | (evt_any ? ev_vec : '0);
      irq_d  = |(stat_d & mask_q[tap_pkg::STAT_W-1:0]);
    end else begin
      // most recent event only; interrupt lasts as long as the event
      stat_d = evt_any ? ev_vec : stat_q;
      irq_d  = evt_any && |(ev_vec & mask_q[tap_pkg::STAT_W-1:0]);
    end
  end

  // bus and configuration next state
  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d  = w_hold_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    ctrl_d    = ctrl_q;
    thr_d     = thr_q;
    lat_d     = lat_q;
    win_d     = win_q;
    mask_d    = mask_q;
    // capture address and data in either order
    if (s_axi_awvalid && !aw_hold_q) begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_q) begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    // commit write; status is read-only and ignores writes
    if (wr_go) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(aw_addr_q) ? tap_pkg::RESP_OKAY : tap_pkg::RESP_DECERR;
      unique case (aw_addr_q)
        tap_pkg::CTRL_OFS:   ctrl_d = merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_00ff;
        tap_pkg::THRESH_OFS: thr_d  = merge(thr_q, w_data_q, w_strb_q) & 32'h00ff_ffff;
        tap_pkg::LAT_OFS:    lat_d  = merge(lat_q, w_data_q, w_strb_q);
        tap_pkg::WIN_OFS:    win_d  = merge(win_q, w_data_q, w_strb_q);
        tap_pkg::MASK_OFS:   mask_d = merge(mask_q, w_data_q, w_strb_q) & 32'h0000_00ff;
        default: ;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // read: data one cycle after the address is taken
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(s_axi_araddr) ? tap_pkg::RESP_OKAY : tap_pkg::RESP_DECERR;
      unique case (s_axi_araddr)
        tap_pkg::CTRL_OFS:   rdata_d = ctrl_q;
        tap_pkg::THRESH_OFS: rdata_d = thr_q;
        tap_pkg::LAT_OFS:    rdata_d = lat_q;
        tap_pkg::WIN_OFS:    rdata_d = win_q;
        tap_pkg::STAT_OFS:   rdata_d = {24'h0, stat_q};
        tap_pkg::MASK_OFS:   rdata_d = mask_q;
        default:             rdata_d = 32'h0000_0000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // bus, configuration and status registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= tap_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= tap_pkg::RESP_OKAY;
      ctrl_q    <= tap_pkg::CTRL_RST;
      thr_q     <= tap_pkg::THRESH_RST;
      lat_q     <= tap_pkg::LAT_RST;
      win_q     <= tap_pkg::WIN_RST;
      mask_q    <= tap_pkg::MASK_RST;
      stat_q    <= '0;
      irq       <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q  <= w_hold_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      ctrl_q    <= ctrl_d;
      thr_q     <= thr_d;
      lat_q     <= lat_d;
      win_q     <= win_d;
      mask_q    <= mask_d;
      stat_q    <= stat_d;
      irq       <= irq_d;
    end
  end

  // bus outputs straight from flops
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready  = !w_hold_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_first_dp_only: assert property (
    first_tap |-> (tap.pulse & dp_en) != 3'h0)
    else $error("window opened by tap on disabled axis");

  a_ignore_latency: assert property (
    (ign_lat && st_q == tap_pkg::DT_ARMED && el_q < win_cfg && |dp_pulse)
    |-> dbl_hit)
    else $error("tap not accepted with latency ignored");

  a_latency_drop: assert property (
    (!ign_lat && st_q == tap_pkg::DT_ARMED && el_q < lat_cfg && el_q < win_cfg)
    |-> !dbl_hit ##1 st_q == tap_pkg::DT_ARMED)
    else $error("tap accepted inside latency interval");

  a_window_reset: assert property (
    (expire && dp_pulse == 3'h0) |=> st_q == tap_pkg::DT_IDLE)
    else $error("detection not reset at window expiry");

  a_double_flag: assert property (
    dbl_hit |=> stat_q[tap_pkg::DBL_BIT] && st_q == tap_pkg::DT_IDLE)
    else $error("double tap flag missing");

  a_axis_flags: assert property (
    evt_any |=> (stat_q[tap_pkg::AXF_LSB +: 3] & $past(axis_hit)) == $past(axis_hit))
    else $error("axis detected flag missing");

  a_event_flag: assert property (
    evt_any |=> stat_q[tap_pkg::EVT_BIT])
    else $error("combined event flag missing");

  a_latch_hold: assert property (
    (latch_en && stat_q[tap_pkg::EVT_BIT] && !rd_stat) |=> stat_q[tap_pkg::EVT_BIT])
    else $error("latched event lost before status read");

  a_double_window: assert property (
    dbl_hit |-> st_q == tap_pkg::DT_ARMED && el_q < win_cfg &&
    (ign_lat || el_q >= lat_cfg))
    else $error("double tap outside latency and window");
endmodule

// ==== bench/double_tap_detector_test.sv ====
`timescale 1ns/1ps
module double_tap_detector_test;
  // clock, reset and sample stream
  logic        sys_clk;
  logic        nrst;
  logic        sample_valid;
  logic [23:0] sample_mag;
  logic [2:0]  sample_neg;
  // lite bus
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  // counters and reference model state
  int          n_fail, checked, cyc, irq_cnt, m_lat, m_win, m_t0, base;
  bit          m_armed;
  logic [7:0]  m_ctrl, m_mask, m_stat;
  logic [31:0] v;
  logic [1:0]  r;

  double_tap_detector #(.CNT_W(16)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .sample_valid(sample_valid), .sample_mag(sample_mag), .sample_neg(sample_neg),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .irq(irq));

  // 40 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // cycle count for tap spacing, interrupt pulse count
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, bready held until bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] rsp);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    // no cycle limit here: only the watchdog ends a wait
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    // bready stays high, so a following call that re-assigns it in this step changes nothing
    rsp = s_axi_bresp;
  endtask

  // read: address held until taken, rready held until rvalid
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    // rready stays high; data taken at the edge rvalid is seen
    d = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  rs;
    axi_rd(a, d, rs);
    cmp(d, exp);
    cmp(32'(rs), 32'(er));
  endtask

  // reference model of one qualified tap
  task automatic model_tap(input int ax, input bit neg);
    bit         dbl;
    logic [7:0] ev;
    dbl = 0;
    ev = 8'h00;
    // elapsed count is zero in the cycle after the opening tap
    if (m_armed && cyc - m_t0 - 1 >= m_win) m_armed = 0;
    if (m_ctrl[tap_pkg::DP_LSB+ax]) begin
      if (!m_armed) begin
        m_armed = 1;
        m_t0 = cyc;
      end else if (m_ctrl[tap_pkg::IGN_BIT] || cyc - m_t0 - 1 >= m_lat) begin
        dbl = 1;
        m_armed = 0;
      end
    end
    if (dbl || m_ctrl[tap_pkg::SP_LSB+ax]) begin
      ev[tap_pkg::EVT_BIT] = 1'b1;
      ev[tap_pkg::DBL_BIT] = dbl;
      ev[tap_pkg::AXF_LSB+ax] = 1'b1;
      ev[tap_pkg::DIR_LSB+ax] = neg;
      m_stat = m_ctrl[tap_pkg::LATCH_BIT] ? (m_stat | ev) : ev;
    end
  endtask

  // one sample on an axis, then a quiet sample so the next can rise again
  task automatic tap(input int ax, input bit neg, input bit hi);
    logic [23:0] m;
    for (int i = 0; i < 3; i++) m[8*i +: 8] = 8'($urandom_range(15, 0));
    if (hi) m[8*ax +: 8] = 8'($urandom_range(255, 16));
    sample_valid <= 1'b1;
    sample_mag   <= m;
    sample_neg   <= 3'(neg) << ax;
    if (hi) model_tap(ax, neg);
    @(posedge sys_clk);
    sample_mag   <= 24'(m[7:0] & 8'h0f);
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    // one idle edge so a following tap never re-drives in this step
    @(posedge sys_clk);
  endtask

  task automatic chk_stat;
    rd_chk(tap_pkg::STAT_OFS, {24'h0, m_stat}, tap_pkg::RESP_OKAY);
    if (m_ctrl[tap_pkg::LATCH_BIT]) m_stat = 8'h00;
  endtask

  // let any armed window lapse, clear status, then configure
  task automatic cfg(input logic [7:0] c, input int lat, input int win, input logic [7:0] mk);
    logic [31:0] d;
    repeat (100) @(posedge sys_clk);
    axi_rd(tap_pkg::STAT_OFS, d, r);
    axi_wr(tap_pkg::CTRL_OFS, {24'h0, c}, 4'hf, r);
    axi_wr(tap_pkg::LAT_OFS, 32'(lat), 4'hf, r);
    axi_wr(tap_pkg::WIN_OFS, 32'(win), 4'hf, r);
    axi_wr(tap_pkg::MASK_OFS, {24'h0, mk}, 4'hf, r);
    m_ctrl = c;
    m_lat = lat;
    m_win = win;
    m_mask = mk;
    m_armed = 0;
    m_stat = 8'h00;
  endtask

  // watchdog, well above the expected run length
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end

  initial begin
    {sample_valid, sample_mag, sample_neg, s_axi_awvalid, s_axi_awaddr} = '0;
    {s_axi_wvalid, s_axi_wdata, s_axi_wstrb, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_araddr, s_axi_rready} = '0;
    {n_fail, checked} = '0;
    nrst = 1'b0;
    void'($urandom(32'h04ad5cbc));
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    // reset values, unmapped place, read-only status
    rd_chk(tap_pkg::CTRL_OFS, tap_pkg::CTRL_RST, tap_pkg::RESP_OKAY);
    rd_chk(tap_pkg::THRESH_OFS, tap_pkg::THRESH_RST, tap_pkg::RESP_OKAY);
    rd_chk(tap_pkg::LAT_OFS, tap_pkg::LAT_RST, tap_pkg::RESP_OKAY);
    rd_chk(tap_pkg::WIN_OFS, tap_pkg::WIN_RST, tap_pkg::RESP_OKAY);
    rd_chk(tap_pkg::MASK_OFS, tap_pkg::MASK_RST, tap_pkg::RESP_OKAY);
    rd_chk(8'h18, 32'h0, tap_pkg::RESP_DECERR);
    axi_wr(8'h18, 32'hffff_ffff, 4'hf, r);
    cmp(32'(r), 32'(tap_pkg::RESP_DECERR));
    axi_wr(tap_pkg::STAT_OFS, 32'hffff_ffff, 4'hf, r);
    rd_chk(tap_pkg::STAT_OFS, 32'h0, tap_pkg::RESP_OKAY);
    // byte strobe merge, reserved bits read zero
    v = $urandom;
    axi_wr(tap_pkg::THRESH_OFS, v, 4'h1, r);
    rd_chk(tap_pkg::THRESH_OFS, {16'h0010, 8'h10, v[7:0]}, tap_pkg::RESP_OKAY);
    axi_wr(tap_pkg::THRESH_OFS, tap_pkg::THRESH_RST, 4'hf, r);
    axi_wr(tap_pkg::CTRL_OFS, v, 4'hf, r);
    rd_chk(tap_pkg::CTRL_OFS, {24'h0, v[7:0]}, tap_pkg::RESP_OKAY);
    // latched single taps on every axis, then a quiet sample
    cfg(8'h1d, 20, 60, 8'hff);
    for (int ax = 0; ax < 3; ax++) begin
      tap(ax, 1'($urandom_range(1, 0)), 1'b1);
      repeat (4) @(posedge sys_clk);
      cmp(32'(irq), 32'h1);
      chk_stat;
      repeat (2) @(posedge sys_clk);
      cmp(32'(irq), 32'h0);
      tap(ax, 1'b0, 1'b0);
      repeat (4) @(posedge sys_clk);
      chk_stat;
    end
    // double taps per axis, a tap pair on the next axis refused
    for (int ax = 0; ax < 3; ax++) begin
      cfg(8'h01 | (8'h20 << ax), 20, 60, 8'hff);
      tap((ax + 1) % 3, 1'b0, 1'b1);
      repeat (30) @(posedge sys_clk);
      tap((ax + 1) % 3, 1'b1, 1'b1);
      tap(ax, 1'b0, 1'b1);
      repeat (30) @(posedge sys_clk);
      tap(ax, 1'b1, 1'b1);
      repeat (4) @(posedge sys_clk);
      chk_stat;
    end
    // second tap inside latency is dropped
    cfg(8'h21, 20, 60, 8'hff);
    tap(0, 1'b0, 1'b1);
    repeat (5) @(posedge sys_clk);
    tap(0, 1'b0, 1'b1);
    repeat (70) @(posedge sys_clk);
    chk_stat;
    // same spacing with latency ignored
    cfg(8'h23, 20, 60, 8'hff);
    tap(0, 1'b1, 1'b1);
    repeat (5) @(posedge sys_clk);
    tap(0, 1'b0, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk_stat;
    // window lapses, late tap becomes a new first one
    cfg(8'h21, 20, 60, 8'hff);
    tap(0, 1'b0, 1'b1);
    repeat (80) @(posedge sys_clk);
    tap(0, 1'b0, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk_stat;
    repeat (26) @(posedge sys_clk);
    tap(0, 1'b1, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk_stat;
    // masked event keeps interrupt low
    cfg(8'h1d, 20, 60, 8'h00);
    tap(2, 1'b1, 1'b1);
    repeat (4) @(posedge sys_clk);
    cmp(32'(irq), 32'h0);
    chk_stat;
    // live mode: one pulse per event, status is the newest event
    cfg(8'h1c, 20, 60, 8'hff);
    base = irq_cnt;
    tap(1, 1'b1, 1'b1);
    repeat (4) @(posedge sys_clk);
    cmp(32'(irq_cnt - base), 32'h1);
    chk_stat;
    chk_stat;
    tap(0, 1'b0, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk_stat;
    complete_run();
  end
endmodule
